// >>> core/amep_pkg.sv
// amep_pkg: shared constants of the motion event parameter block
// assumes: 100 MHz system clock, samples scaled at 1/256 g per lsb
package amep_pkg;
   // ***********************
   // timing
   // ***********************
   localparam int CLK_PERIOD_NS = 10;
   localparam int DLY_STEP_NS   = 2000000;
   localparam int SEC_STEP_NS   = 1000000000;
   localparam int DLY_STEP_CYC  = DLY_STEP_NS / CLK_PERIOD_NS;
   localparam int SEC_STEP_CYC  = SEC_STEP_NS / CLK_PERIOD_NS;
   // ***********************
   // register indexes, byte address is four times the index
   // ***********************
   localparam logic [7:0] IDX_LOW_DUR   = 8'h22;
   localparam logic [7:0] IDX_LOW_THR   = 8'h23;
   localparam logic [7:0] IDX_HYST      = 8'h24;
   localparam logic [7:0] IDX_HIGH_DUR  = 8'h25;
   localparam logic [7:0] IDX_HIGH_THR  = 8'h26;
   localparam logic [7:0] IDX_MOT_DUR   = 8'h27;
   localparam logic [7:0] IDX_ANY_THR   = 8'h28;
   localparam logic [7:0] IDX_STILL_THR = 8'h29;
   localparam logic [7:0] IDX_CTRL      = 8'h2a;
   localparam logic [7:0] IDX_STAT      = 8'h2b;
   localparam logic [7:0] IDX_MASK      = 8'h2c;
   // ***********************
   // reset values
   // ***********************
   localparam logic [7:0] LOW_DUR_RST   = 8'h09;
   localparam logic [7:0] LOW_THR_RST   = 8'h30;
   localparam logic [7:0] HYST_RST      = 8'h81;
   localparam logic [7:0] HIGH_DUR_RST  = 8'h0f;
   localparam logic [7:0] HIGH_THR_RST  = 8'hc0;
   localparam logic [7:0] MOT_DUR_RST   = 8'h00;
   localparam logic [7:0] ANY_THR_RST   = 8'h14;
   localparam logic [7:0] STILL_THR_RST = 8'h14;
   localparam logic [7:0] CTRL_RST      = 8'h00;
   localparam logic [7:0] MASK_RST      = 8'h00;
   // ***********************
   // fields
   // ***********************
   localparam logic [7:0] HYST_WMASK    = 8'hc7;
   localparam logic [7:0] CTRL_WMASK    = 8'h07;
   localparam logic [7:0] EV_WMASK      = 8'h0f;
   localparam int HIGH_G_HYSTERESIS_FIELD_LSB   = 6;
   localparam int LOW_MODE_BIT  = 2;
   localparam int LOW_G_HYSTERESIS_FIELD_LSB    = 0;
   localparam int SLOPE_DUR_LSB = 0;
   localparam int STILL_DUR_LSB = 2;
   localparam int CTRL_SEL_BIT  = 2;
   localparam int EV_LOW        = 0;
   localparam int EV_HIGH       = 1;
   localparam int EV_ANY        = 2;
   localparam int EV_STILL      = 3;
   // scale shifts in 1/256 g: 7.81 mg = 2 lsb, 125 mg = 32 lsb, 3.91 mg = 1 lsb
   localparam logic [3:0] THR_SH = 4'h1;
   localparam logic [3:0] HY_SH  = 4'h5;
   localparam logic [3:0] SLP_SH = 4'h0;
endpackage

// >>> core/amep_tick.sv
// amep_tick: periodic one-cycle tick from the system clock
// assumes: div of at least two
`timescale 1ns/1ps
module amep_tick #(
   parameter int DIV = 200000
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   output logic      tick
);
   localparam int W = $clog2(DIV);
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic         tick_nxt;

   always_comb begin
      tick_nxt = (cnt_r == LAST);
      cnt_nxt  = tick_nxt ? '0 : cnt_r + W'(1);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick  <= tick_nxt;
      end
   end
endmodule // amep_tick

// >>> core/amep_persist.sv
// amep_persist: counts ticks while a condition holds, fires at the target
// assumes: cond and tick come from logic on the same clock
`timescale 1ns/1ps
module amep_persist (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       cond,
   input  wire logic       tick,
   input  wire logic [8:0] target,
   output logic            fire
);
   logic [8:0] cnt_r;
   logic [8:0] cnt_nxt;

   always_comb begin
      if (!cond)
         cnt_nxt = '0;
      else if (tick && cnt_r < target)
         cnt_nxt = cnt_r + 9'h001;
      else
         cnt_nxt = cnt_r;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         cnt_r <= '0;
      else
         cnt_r <= cnt_nxt;
   end

   assign fire = cond && (cnt_r >= target);
endmodule // amep_persist

// >>> core/amep_top.sv
// amep_top: motion event parameter registers and detectors behind ahb-lite
// assumes: one sample strobe per new acceleration and slope sample set
// How it works
// - low-g threshold is field times 7.81 mg, reset gives 375 mg
// - low-g hysteresis is field times 125 mg in every range
// - low-g checks each axis in mode 0, the axis sum in mode 1
// - high-g hysteresis is field times 125/250/500/1000 mg per range
// - high-g fires after (delay field plus one) times 2 ms, reset 32 ms
// - high-g threshold step is 7.81/15.63/31.25/62.5 mg per range
// - slow-motion fires after (duration bits 3:2 plus one) slopes above
// - no-motion fires once no slope exceeded threshold for the coded time
// - no-motion seconds: n+1, n*4+20, or n*8+88 by top bits
// - any-motion fires after (slope duration plus one) slopes above
// - low-g fires after (delay field plus one) times 2 ms
// - still threshold step is 3.91/7.81/15.63/31.25 mg per range
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
module amep_top #(
   parameter int DLY_CYC = amep_pkg::DLY_STEP_CYC,
   parameter int SEC_CYC = amep_pkg::SEC_STEP_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic [1:0]  range_sel,
   input  wire logic        smp_valid,
   input  wire logic [15:0] acc_x,
   input  wire logic [15:0] acc_y,
   input  wire logic [15:0] acc_z,
   input  wire logic [15:0] slp_x,
   input  wire logic [15:0] slp_y,
   input  wire logic [15:0] slp_z,
   output logic [3:0]       evt_r,
   output logic             irq_r
);
   // ***********************
   // helpers
   // ***********************
   function automatic logic [16:0] amep_abs(input logic [15:0] a);
      logic [16:0] e;
      e = {a[15], a};
      amep_abs = a[15] ? (~e + 17'h00001) : e;
   endfunction

   function automatic logic [17:0] amep_scale(input logic [7:0] v, input logic [3:0] sh);
      amep_scale = {10'h000, v} << sh;
   endfunction

   function automatic logic [8:0] amep_nomot_sec(input logic [5:0] d);
      if (d[5])
         amep_nomot_sec = {1'b0, d[4:0], 3'h0} + 9'h058;
      else if (d[4])
         amep_nomot_sec = {3'h0, d[3:0], 2'h0} + 9'h014;
      else
         amep_nomot_sec = {5'h00, d[3:0]} + 9'h001;
   endfunction

   // ***********************
   // registers
   // ***********************
   logic [7:0] low_dur_r, low_thr_r, hyst_r, high_dur_r, high_thr_r;
   logic [7:0] mot_dur_r, any_thr_r, still_thr_r, ctrl_r, mask_r;
   logic [3:0] stat_r, stat_nxt;
   logic       wr_pend_r, wr_pend_nxt;
   logic [7:0] wr_idx_r, wr_idx_nxt;
   logic [31:0] rd_nxt;
   logic       irq_nxt;
   logic       aphase, rd_stat;
   logic [7:0] aidx, wd;
   logic [3:0] ev_now;

   always_comb begin
      aphase      = hsel && htrans[1] && hready;
      aidx        = (haddr[31:10] == '0) ? haddr[9:2] : 8'hff;
      wd          = hwdata[7:0];
      wr_pend_nxt = aphase && hwrite;
      wr_idx_nxt  = aidx;
      rd_stat     = aphase && !hwrite && (aidx == amep_pkg::IDX_STAT);
      rd_nxt      = '0;
      if (aphase && !hwrite) begin
         unique case (aidx)
            amep_pkg::IDX_LOW_DUR:   rd_nxt[7:0] = low_dur_r;
            amep_pkg::IDX_LOW_THR:   rd_nxt[7:0] = low_thr_r;
            amep_pkg::IDX_HYST:      rd_nxt[7:0] = hyst_r;
            amep_pkg::IDX_HIGH_DUR:  rd_nxt[7:0] = high_dur_r;
            amep_pkg::IDX_HIGH_THR:  rd_nxt[7:0] = high_thr_r;
            amep_pkg::IDX_MOT_DUR:   rd_nxt[7:0] = mot_dur_r;
            amep_pkg::IDX_ANY_THR:   rd_nxt[7:0] = any_thr_r;
            amep_pkg::IDX_STILL_THR: rd_nxt[7:0] = still_thr_r;
            amep_pkg::IDX_CTRL:      rd_nxt[7:0] = ctrl_r;
            amep_pkg::IDX_STAT:      rd_nxt[3:0] = stat_r;
            amep_pkg::IDX_MASK:      rd_nxt[7:0] = mask_r;
            default:                 rd_nxt      = '0;
         endcase
      end
      // a new event wins over the read clear
      stat_nxt = (stat_r & ~{4{rd_stat}}) | (ev_now & ~evt_r);
      irq_nxt  = |(stat_r & mask_r[3:0]);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         low_dur_r   <= amep_pkg::LOW_DUR_RST;
         low_thr_r   <= amep_pkg::LOW_THR_RST;
         hyst_r      <= amep_pkg::HYST_RST;
         high_dur_r  <= amep_pkg::HIGH_DUR_RST;
         high_thr_r  <= amep_pkg::HIGH_THR_RST;
         mot_dur_r   <= amep_pkg::MOT_DUR_RST;
         any_thr_r   <= amep_pkg::ANY_THR_RST;
         still_thr_r <= amep_pkg::STILL_THR_RST;
         ctrl_r      <= amep_pkg::CTRL_RST;
         mask_r      <= amep_pkg::MASK_RST;
         stat_r      <= '0;
         wr_pend_r   <= 1'b0;
         wr_idx_r    <= '0;
         hrdata      <= '0;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         irq_r       <= 1'b0;
      end else begin
         wr_pend_r <= wr_pend_nxt;
         wr_idx_r  <= wr_idx_nxt;
         hrdata    <= rd_nxt;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         stat_r    <= stat_nxt;
         irq_r     <= irq_nxt;
         if (wr_pend_r) begin
            unique case (wr_idx_r)
               amep_pkg::IDX_LOW_DUR:   low_dur_r   <= wd;
               amep_pkg::IDX_LOW_THR:   low_thr_r   <= wd;
               amep_pkg::IDX_HYST:      hyst_r      <= wd & amep_pkg::HYST_WMASK;
               amep_pkg::IDX_HIGH_DUR:  high_dur_r  <= wd;
               amep_pkg::IDX_HIGH_THR:  high_thr_r  <= wd;
               amep_pkg::IDX_MOT_DUR:   mot_dur_r   <= wd;
               amep_pkg::IDX_ANY_THR:   any_thr_r   <= wd;
               amep_pkg::IDX_STILL_THR: still_thr_r <= wd;
               amep_pkg::IDX_CTRL:      ctrl_r      <= wd & amep_pkg::CTRL_WMASK;
               amep_pkg::IDX_MASK:      mask_r      <= wd & amep_pkg::EV_WMASK;
               default:                 ;
            endcase
         end
      end
   end

   // ***********************
   // sample conditions
   // ***********************
   logic [16:0] ax, ay, az, sx, sy, sz;
   logic [17:0] asum, lt, lhy, low_lim, ht, hhy, high_lim, any_lim, still_lim;
   logic [1:0]  low_g_hysteresis_field, high_g_hysteresis_field;
   logic        low_mode, still_sel;
   logic        low_hit, high_hit, any_hit, still_hit;
   logic        low_act_r, high_act_r, any_act_r, still_act_r, smp_d_r;
   logic        low_act_nxt, high_act_nxt, any_act_nxt, still_act_nxt;

   always_comb begin
      ax        = amep_abs(acc_x);
      ay        = amep_abs(acc_y);
      az        = amep_abs(acc_z);
      sx        = amep_abs(slp_x);
      sy        = amep_abs(slp_y);
      sz        = amep_abs(slp_z);
      asum      = {1'b0, ax} + {1'b0, ay} + {1'b0, az};
      low_g_hysteresis_field    = hyst_r[amep_pkg::LOW_G_HYSTERESIS_FIELD_LSB +: 2];
      high_g_hysteresis_field   = hyst_r[amep_pkg::HIGH_G_HYSTERESIS_FIELD_LSB +: 2];
      low_mode  = hyst_r[amep_pkg::LOW_MODE_BIT];
      still_sel = ctrl_r[amep_pkg::CTRL_SEL_BIT];
      lt        = amep_scale(low_thr_r, amep_pkg::THR_SH);
      lhy       = amep_scale({6'h00, low_g_hysteresis_field}, amep_pkg::HY_SH);
      low_lim   = low_act_r ? lt + lhy : lt;
      ht        = amep_scale(high_thr_r, amep_pkg::THR_SH + {2'b00, range_sel});
      hhy       = amep_scale({6'h00, high_g_hysteresis_field}, amep_pkg::HY_SH + {2'b00, range_sel});
      high_lim  = (high_act_r && ht > hhy) ? ht - hhy : (high_act_r ? '0 : ht);
      any_lim   = amep_scale(any_thr_r, amep_pkg::SLP_SH + {2'b00, range_sel});
      still_lim = amep_scale(still_thr_r, amep_pkg::SLP_SH + {2'b00, range_sel});
      if (low_mode)
         low_hit = asum < low_lim;
      else
         low_hit = ({1'b0, ax} < low_lim) && ({1'b0, ay} < low_lim)
                   && ({1'b0, az} < low_lim);
      high_hit  = ({1'b0, ax} > high_lim) || ({1'b0, ay} > high_lim)
                  || ({1'b0, az} > high_lim);
      any_hit   = ({1'b0, sx} > any_lim) || ({1'b0, sy} > any_lim)
                  || ({1'b0, sz} > any_lim);
      still_hit = ({1'b0, sx} > still_lim) || ({1'b0, sy} > still_lim)
                  || ({1'b0, sz} > still_lim);
      low_act_nxt   = smp_valid ? low_hit : low_act_r;
      high_act_nxt  = smp_valid ? high_hit : high_act_r;
      any_act_nxt   = smp_valid ? any_hit : any_act_r;
      still_act_nxt = smp_valid ? still_hit : still_act_r;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         low_act_r   <= 1'b0;
         high_act_r  <= 1'b0;
         any_act_r   <= 1'b0;
         still_act_r <= 1'b0;
         smp_d_r     <= 1'b0;
      end else begin
         low_act_r   <= low_act_nxt;
         high_act_r  <= high_act_nxt;
         any_act_r   <= any_act_nxt;
         still_act_r <= still_act_nxt;
         smp_d_r     <= smp_valid;
      end
   end

   // ***********************
   // delay counters
   // ***********************
   logic tick_dly, tick_sec;
   logic low_fire, high_fire, any_fire, slow_fire, nomot_fire;

   amep_tick #(.DIV(DLY_CYC)) u_tick_dly (.clk_sys(clk_sys), .rst_n(rst_n), .tick(tick_dly));
   amep_tick #(.DIV(SEC_CYC)) u_tick_sec (.clk_sys(clk_sys), .rst_n(rst_n), .tick(tick_sec));

   amep_persist u_low (.clk_sys(clk_sys), .rst_n(rst_n), .cond(low_act_r), .tick(tick_dly),
      .target({1'b0, low_dur_r} + 9'h001), .fire(low_fire));
   amep_persist u_high (.clk_sys(clk_sys), .rst_n(rst_n), .cond(high_act_r), .tick(tick_dly),
      .target({1'b0, high_dur_r} + 9'h001), .fire(high_fire));
   amep_persist u_any (.clk_sys(clk_sys), .rst_n(rst_n), .cond(any_act_r), .tick(smp_d_r),
      .target({7'h00, mot_dur_r[amep_pkg::SLOPE_DUR_LSB +: 2]} + 9'h001),
      .fire(any_fire));
   amep_persist u_slow (.clk_sys(clk_sys), .rst_n(rst_n), .cond(still_act_r), .tick(smp_d_r),
      .target({7'h00, mot_dur_r[amep_pkg::STILL_DUR_LSB +: 2]} + 9'h001),
      .fire(slow_fire));
   amep_persist u_nomot (.clk_sys(clk_sys), .rst_n(rst_n), .cond(!still_act_r),
      .tick(tick_sec), .target(amep_nomot_sec(mot_dur_r[amep_pkg::STILL_DUR_LSB +: 6])),
      .fire(nomot_fire));

   always_comb begin
      ev_now                     = '0;
      ev_now[amep_pkg::EV_LOW]   = low_fire;
      ev_now[amep_pkg::EV_HIGH]  = high_fire;
      ev_now[amep_pkg::EV_ANY]   = any_fire;
      ev_now[amep_pkg::EV_STILL] = still_sel ? nomot_fire : slow_fire;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         evt_r <= '0;
      else
         evt_r <= ev_now;
   end

   // ***********************
   // checks
   // ***********************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_low_rst;
      $rose(rst_n) |-> (low_thr_r == 8'h30) && (lt == 18'd96);
   endproperty
   a_low_rst: assert property (p_low_rst) else $error("low-g threshold reset wrong");
   property p_low_g_hysteresis_field;
      (smp_valid && low_act_r && !low_mode && ax < lt + 18'(low_g_hysteresis_field) * 18'd32
       && ay < lt + 18'(low_g_hysteresis_field) * 18'd32 && az < lt + 18'(low_g_hysteresis_field) * 18'd32) |=> low_act_r;
   endproperty
   a_low_g_hysteresis_field: assert property (p_low_g_hysteresis_field) else $error("low-g hysteresis lost");
   property p_low_sum;
      (smp_valid && low_mode && asum >= low_lim) |=> !low_act_r;
   endproperty
   a_low_sum: assert property (p_low_sum) else $error("low-g sum mode wrong");
   property p_high_g_hysteresis_field;
      (smp_valid && high_act_r && ax != 17'h00000
       && {1'b0, ax} + (18'(high_g_hysteresis_field) * 18'd32 << range_sel) > ht)
      |=> high_act_r;
   endproperty
   a_high_g_hysteresis_field: assert property (p_high_g_hysteresis_field) else $error("high-g hysteresis wrong");
   property p_high_clear;
      !high_act_r |-> !ev_now[amep_pkg::EV_HIGH] ##1 !evt_r[amep_pkg::EV_HIGH];
   endproperty
   a_high_clear: assert property (p_high_clear) else $error("high-g fired early");
   property p_nomot;
      (still_sel && ev_now[amep_pkg::EV_STILL]) |-> !still_act_r;
   endproperty
   a_nomot: assert property (p_nomot) else $error("no-motion fired with motion");
   property p_any;
      $rose(evt_r[amep_pkg::EV_ANY]) |-> $past(any_act_r, 1) && $past(any_act_r, 2);
   endproperty
   a_any: assert property (p_any) else $error("any-motion without slope");
   property p_hold;
      !smp_valid |=> $stable(low_act_r) && $stable(high_act_r) && $stable(any_act_r);
   endproperty
   a_hold: assert property (p_hold) else $error("condition moved without sample");
   property p_irq;
      (|(stat_r & mask_r[3:0])) |=> irq_r;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   c_low: cover property ($rose(evt_r[amep_pkg::EV_LOW]));
   c_high: cover property ($rose(evt_r[amep_pkg::EV_HIGH]));
   c_still: cover property (still_sel ##0 $rose(evt_r[amep_pkg::EV_STILL]));
   c_irq: cover property ($rose(irq_r));
endmodule // amep_top

// >>> sim/amep_partner.sv
// amep_partner: sample path model, streams acceleration and slope sets
// assumes: the bench holds req high while it wants samples, one clock
`timescale 1ns/1ps
module amep_partner #(
   parameter int PER = 4
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        req,
   input  wire logic [95:0] smp_in,
   output logic             smp_valid,
   output logic [15:0]      acc_x,
   output logic [15:0]      acc_y,
   output logic [15:0]      acc_z,
   output logic [15:0]      slp_x,
   output logic [15:0]      slp_y,
   output logic [15:0]      slp_z
);
   logic [7:0] cnt_r;
   // one sample every PER cycles keeps the strobe spacing legal
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt_r <= 8'h00;
         smp_valid <= 1'b0;
         {acc_x, acc_y, acc_z, slp_x, slp_y, slp_z} <= 96'h0;
      end else begin
         cnt_r <= (cnt_r == 8'(PER - 1)) ? 8'h00 : cnt_r + 8'h01;
         smp_valid <= req && (cnt_r == 8'h00);
         if (req && (cnt_r == 8'h00)) begin
            {acc_x, acc_y, acc_z, slp_x, slp_y, slp_z} <= smp_in;
         end else if (smp_valid) begin
            // stale data goes inverted once the strobe is gone
            {acc_x, acc_y, acc_z, slp_x, slp_y, slp_z} <=
               ~{acc_x, acc_y, acc_z, slp_x, slp_y, slp_z};
         end
      end
   end
endmodule // amep_partner

// >>> sim/amep_bench.sv
// amep_bench: self-checking bench of the motion event block
// assumes: ahb-lite single master, sample model on the far side
`timescale 1ns/1ps
module amep_bench;
   localparam int DLY = 20;
   localparam int SEC = 50;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        req = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [1:0]  range_sel = 2'h0;
   logic [1:0]  r;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic [31:0] xs = 32'd33;
   logic [95:0] vals = 96'h0;
   logic        hreadyout, hresp, smp_valid, irq_r;
   logic [15:0] acc_x, acc_y, acc_z, slp_x, slp_y, slp_z, thr, hy, h;
   logic [3:0]  evt_r;
   logic [7:0]  f, hyf, v;
   logic [7:0]  codes [3] = '{8'h00, 8'h13, 8'h21};
   int          error_cnt = 0;
   int          total_checks = 0;
   int          n;

   always #5 clk_sys = ~clk_sys;

   amep_top #(.DLY_CYC(DLY), .SEC_CYC(SEC)) amep_top_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .range_sel(range_sel),
      .smp_valid(smp_valid), .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z),
      .slp_x(slp_x), .slp_y(slp_y), .slp_z(slp_z), .evt_r(evt_r), .irq_r(irq_r));

   amep_partner #(.PER(4)) amep_partner_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .req(req), .smp_in(vals),
      .smp_valid(smp_valid), .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z),
      .slp_x(slp_x), .slp_y(slp_y), .slp_z(slp_z));

   // ***********************
   // helpers
   // ***********************
   function automatic logic [31:0] rnd();
      xs = xs ^ (xs << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
      return xs;
   endfunction

   function automatic logic [7:0] rst_of(input logic [7:0] i);
      case (i)
         amep_pkg::IDX_LOW_DUR:   return amep_pkg::LOW_DUR_RST;
         amep_pkg::IDX_LOW_THR:   return amep_pkg::LOW_THR_RST;
         amep_pkg::IDX_HYST:      return amep_pkg::HYST_RST;
         amep_pkg::IDX_HIGH_DUR:  return amep_pkg::HIGH_DUR_RST;
         amep_pkg::IDX_HIGH_THR:  return amep_pkg::HIGH_THR_RST;
         amep_pkg::IDX_MOT_DUR:   return amep_pkg::MOT_DUR_RST;
         amep_pkg::IDX_ANY_THR:   return amep_pkg::ANY_THR_RST;
         amep_pkg::IDX_STILL_THR: return amep_pkg::STILL_THR_RST;
         amep_pkg::IDX_CTRL:      return amep_pkg::CTRL_RST;
         amep_pkg::IDX_MASK:      return amep_pkg::MASK_RST;
         default:                 return 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] mask_of(input logic [7:0] i);
      case (i)
         amep_pkg::IDX_HYST: return amep_pkg::HYST_WMASK;
         amep_pkg::IDX_CTRL: return amep_pkg::CTRL_WMASK;
         amep_pkg::IDX_MASK: return amep_pkg::EV_WMASK;
         amep_pkg::IDX_STAT: return 8'h00;
         default:            return (i >= 8'h22 && i <= 8'h2c) ? 8'hff : 8'h00;
      endcase
   endfunction

   function automatic int secs_of(input logic [5:0] c);
      if (c[5:4] == 2'b00) return int'(c[3:0]) + 1;
      if (c[5:4] == 2'b01) return int'(c[3:0]) * 4 + 20;
      return int'(c[4:0]) * 8 + 88;
   endfunction

   task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= wr;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic ev(input string nm, input int b, input logic e);
      chk(nm, {31'h0, e}, {31'h0, evt_r[b]});
   endtask

   task automatic samples(input int k);
      req <= 1'b1;
      repeat (k) begin
         do @(posedge clk_sys); while (smp_valid !== 1'b1);
      end
      req <= 1'b0;
      repeat (5) @(posedge clk_sys);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk_sys);
      error_cnt++;
      wrap_up();
   end

   // ***********************
   // tests
   // ***********************
   initial begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      for (int i = 'h22; i <= 'h30; i++) begin
         bus(8'(i), 1'b0, 8'h00);
         chk("reset", {24'h0, rst_of(8'(i))}, rd);
      end
      $display("test reset done");
      for (int i = 'h22; i <= 'h30; i++) begin
         v = 8'(rnd());
         // long no-motion time keeps status quiet until it is read
         if (8'(i) == amep_pkg::IDX_MOT_DUR) v[7] = 1'b1;
         bus(8'(i), 1'b1, v);
         bus(8'(i), 1'b0, 8'h00);
         chk("rw", {24'h0, v & mask_of(8'(i))}, rd);
      end
      $display("test regs done");
      for (int d = 0; d < 4; d++) begin
         r = 2'(rnd());
         f = 8'(rnd());
         thr = 16'(f) << r;
         range_sel <= r;
         bus(amep_pkg::IDX_ANY_THR, 1'b1, f);
         bus(amep_pkg::IDX_STILL_THR, 1'b1, f);
         bus(amep_pkg::IDX_CTRL, 1'b1, 8'h00);
         bus(amep_pkg::IDX_MOT_DUR, 1'b1, {4'h0, 2'(d), 2'(d)});
         vals <= {48'h0, thr, thr, thr};
         samples(1);
         h = rnd() % 2 != 0 ? 16'h0 - (thr + 16'h1) : thr + 16'h1;
         vals <= {48'h0, h, thr, thr};
         if (d > 0) begin
            samples(d);
            ev("any_early", 2, 1'b0);
            ev("slow_early", 3, 1'b0);
         end
         samples(1);
         ev("any", 2, 1'b1);
         ev("slow", 3, 1'b1);
      end
      $display("test slope counts done");
      vals <= 96'h0;
      samples(1);
      bus(amep_pkg::IDX_MASK, 1'b1, 8'h00);
      bus(amep_pkg::IDX_MOT_DUR, 1'b1, 8'h00);
      bus(amep_pkg::IDX_STAT, 1'b0, 8'h00);
      vals <= {48'h0, h, thr, thr};
      samples(1);
      chk("irq_masked", 32'h0, {31'h0, irq_r});
      vals <= 96'h0;
      samples(1);
      bus(amep_pkg::IDX_MASK, 1'b1, 8'h04);
      repeat (2) @(posedge clk_sys);
      chk("irq_on", 32'h1, {31'h0, irq_r});
      bus(amep_pkg::IDX_STAT, 1'b0, 8'h00);
      chk("stat_set", 32'h1, {31'h0, rd[2]});
      repeat (2) @(posedge clk_sys);
      chk("irq_off", 32'h0, {31'h0, irq_r});
      bus(amep_pkg::IDX_STAT, 1'b0, 8'h00);
      chk("stat_clr", 32'h0, {31'h0, rd[2]});
      $display("test irq done");
      for (int k = 0; k < 2; k++) begin
         r = 2'(rnd());
         f = 8'h40 + 8'(rnd() % 64);
         hyf = 8'(rnd() % 4);
         n = int'(rnd() % 4) + 1;
         range_sel <= r;
         bus(amep_pkg::IDX_HIGH_THR, 1'b1, f);
         bus(amep_pkg::IDX_HYST, 1'b1, {hyf[1:0], 6'h00});
         bus(amep_pkg::IDX_HIGH_DUR, 1'b1, 8'(n - 1));
         thr = (16'(f) * 16'h2) << r;
         hy = (16'(hyf) * 16'h20) << r;
         vals <= 96'h0;
         samples(1);
         vals <= {thr + 16'h1, 80'h0};
         if (n > 1) begin
            samples((n - 1) * 5 - 1);
            ev("high_early", 1, 1'b0);
         end
         samples(12);
         ev("high", 1, 1'b1);
         if (hy != 16'h0) begin
            vals <= {thr - hy + 16'h1, 80'h0};
            samples(2);
            ev("high_hold", 1, 1'b1);
         end
         vals <= {thr - hy, 80'h0};
         samples(2);
         ev("high_drop", 1, 1'b0);
      end
      $display("test high done");
      r = 2'(rnd());
      range_sel <= r;
      f = 8'd100 + 8'(rnd() % 28);
      hyf = 8'(rnd() % 3) + 8'h1;
      thr = 16'(f) * 16'h2;
      hy = 16'(hyf) * 16'h20;
      bus(amep_pkg::IDX_LOW_THR, 1'b1, f);
      bus(amep_pkg::IDX_LOW_DUR, 1'b1, 8'(rnd() % 3));
      bus(amep_pkg::IDX_HYST, 1'b1, {5'h0, 1'b1, hyf[1:0]});
      vals <= {16'(f), 16'(f), 16'(f), 48'h0};
      samples(20);
      ev("low_sum_off", 0, 1'b0);
      vals <= {16'(f / 2), 16'(f / 2), 64'h0};
      samples(20);
      ev("low_sum_on", 0, 1'b1);
      bus(amep_pkg::IDX_HYST, 1'b1, {5'h0, 1'b0, hyf[1:0]});
      vals <= {16'(f), 16'(f), 16'(f), 48'h0};
      samples(20);
      ev("low_axis_on", 0, 1'b1);
      h = thr + hy - 16'h1;
      vals <= {h, h, h, 48'h0};
      samples(2);
      ev("low_hold", 0, 1'b1);
      h = thr + hy;
      vals <= {h, h, h, 48'h0};
      samples(2);
      ev("low_drop", 0, 1'b0);
      $display("test low done");
      bus(amep_pkg::IDX_CTRL, 1'b1, 8'h04);
      for (int k = 0; k < 3; k++) begin
         r = 2'(rnd());
         range_sel <= r;
         thr = 16'h10 << r;
         n = secs_of(codes[k][5:0]);
         bus(amep_pkg::IDX_STILL_THR, 1'b1, 8'h10);
         bus(amep_pkg::IDX_MOT_DUR, 1'b1, {codes[k][5:0], 2'h0});
         vals <= {48'h0, thr + 16'h1, 32'h0};
         samples(1);
         vals <= {48'h0, 16'h0, thr, 16'h0};
         if (n > 1) begin
            samples((n - 1) * SEC / 4 - 2);
            ev("still_early", 3, 1'b0);
         end
         samples(20);
         ev("still", 3, 1'b1);
      end
      $display("test no-motion done");
      wrap_up();
   end
endmodule // amep_bench
